// ### verilog/lcd_cmd_pkg.sv
// Constants shared by the serial command decoder and its testbench; the byte FIFO imports none of them.
// Assumes a single system clock; all counts are in system clock cycles.
package lcd_cmd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int CMD_W     = 8;           // Serial byte width
  localparam int ENTRY_W   = CMD_W + 1;   // Byte plus command/data flag
  localparam int PTR_W     = 7;           // Display RAM pointer width
  localparam int RAM_WORDS = 128;         // Display RAM bytes
  localparam int FRAME_W   = 20;          // Frame divider counter width

  ////////////////////////////////////////////////////////////////////////////
  // Opcode masks and values
  localparam logic [7:0] MASK_GROUP    = 8'hF8;  // Mode set / frame set
  localparam logic [7:0] MASK_DMODE    = 8'hFC;  // Data mode commands
  localparam logic [7:0] MASK_BITCMD   = 8'hE0;  // Set / reset bit
  localparam logic [7:0] OPC_MODESET   = 8'h18;
  localparam logic [7:0] OPC_FRAME     = 8'h10;
  localparam logic [2:0] FRAME_MAX     = 3'h4;   // Highest frame code
  localparam logic [7:0] OPC_PTR_MAX   = 8'hE7;  // Highest pointer load
  localparam logic [7:0] OPC_WRITE     = 8'h64;
  localparam logic [7:0] OPC_READ      = 8'h60;
  localparam logic [7:0] OPC_AND       = 8'h6C;
  localparam logic [7:0] OPC_OR        = 8'h68;
  localparam logic [7:0] OPC_CHAR      = 8'h72;
  localparam logic [7:0] OPC_SETBIT    = 8'h40;
  localparam logic [7:0] OPC_CLRBIT    = 8'h20;
  localparam logic [7:0] OPC_DISP_ON   = 8'h09;
  localparam logic [7:0] OPC_DISP_OFF  = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int PTR_LOAD_BIT = 7;   // Set in a pointer load
  localparam int ENTRY_CMD    = 8;   // Command flag inside a FIFO entry
  localparam int BITCMD_MOD_LO = 3;  // Pointer change field of bit commands
  localparam int MODE_DRIVE   = 0;   // Mode bit: 16-row drive, row port alt
  localparam int MODE_BANK    = 1;   // Mode bit: RAM bank
  localparam int MODE_SYNCM   = 2;   // Mode bit: sync port master

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [2:0] MODE_RST    = 3'h0;
  localparam logic [2:0] FRAME_RST   = 3'h0;
  localparam logic [4:0] PIN_IDLE    = 5'h09;  // Chip select and serial clock high at rest
  localparam logic [2:0] GLYPH_COLS  = 3'h5;   // Columns per character
  localparam logic [2:0] LAST_BIT    = 3'h7;   // Eighth serial bit

  // Data byte handling selected by the last mode command
  typedef enum logic [2:0] {MODE_WRITE, MODE_READ, MODE_AND, MODE_OR, MODE_CHAR} data_mode_t;

endpackage

// ### verilog/byte_stream_if.sv
// Valid/ready carrier between the decoder and its byte FIFO.
// Both ends run on the same system clock.
interface byte_stream_if #(parameter int WIDTH = 9);
  logic             valid;  // Entry offered
  logic             ready;  // Entry accepted
  logic [WIDTH-1:0] data;   // Entry payload

  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface

// ### verilog/byte_fifo.sv
// Flip-flop FIFO carrying received bytes from the serial side to the executor.
// Assumes one clock and a synchronous active low reset copy.
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rstN,
  // Fill side
  byte_stream_if.consumer  inPort,
  // Drain side
  byte_stream_if.producer  outPort
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];  // Entry storage
  logic [AW:0]      wrPtr;          // Write index with wrap bit
  logic [AW:0]      rdPtr;          // Read index with wrap bit
  logic             full;
  logic             empty;
  logic             doWrite;
  logic             doRead;

  // Honest flags from the wrap bits
  assign empty         = (wrPtr == rdPtr);
  assign full          = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign inPort.ready  = !full;
  assign outPort.valid = !empty;
  assign outPort.data  = store[rdPtr[AW-1:0]];
  assign doWrite       = inPort.valid && !full;
  assign doRead        = outPort.ready && !empty;

  ////////////////////////////////////////////////////////////////////////////
  // Pointers
  always_ff @(posedge clk)
  begin
    if (!rstN)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (doWrite)
        wrPtr <= wrPtr + 1'b1;
      if (doRead)
        rdPtr <= rdPtr + 1'b1;
    end
  end

  // Storage, no reset needed for data
  always_ff @(posedge clk)
  begin
    if (doWrite)
      store[wrPtr[AW-1:0]] <= inPort.data;
  end

  a_fifo_no_wrap: assert property (@(posedge clk) disable iff (!rstN)
    full |=> !(wrPtr != $past(wrPtr) && rdPtr == $past(rdPtr)))
    else $error("FIFO written while full");

endmodule

// ### verilog/lcd_serial_command_decoder.sv
// Serial command decoder of a dot-matrix LCD controller: byte receiver,
// FIFO, command executor, display RAM and frame timing.
// Assumes host pins are asynchronous to sys_clk and sampled twice.
// Operation
// RULE1 - 0x18-0x1F sets drive configuration mode
// RULE2 - Mode set low bits pick row port
// RULE3 - Mode set picks sync port, RAM bank
// RULE4 - 0x10-0x14 sets frame rate from low bits
// RULE5 - 0x80-0xE7 loads seven-bit RAM pointer
// RULE6 - 0x64-0x67 write mode, store then move pointer
// RULE7 - 0x60-0x63 read mode, shift RAM byte out
// RULE8 - 0x6C-0x6F AND data into RAM byte
// RULE9 - 0x68-0x6B OR data into RAM byte
// RULE10 - 0x72 character mode via glyph generator
// RULE11 - Glyph columns written, pointer advances five
// RULE12 - 0x40-0x5F sets one RAM bit
// RULE13 - 0x20-0x3F clears one RAM bit
// RULE14 - Command/data line routes each byte
// RULE15 - Busy low means ready for next byte
// RULE16 - Eight-bit transfers on serial clock, chip-selected
// RULE17 - Bit commands: bit low three, move next two
// RULE18 - Two-bit move code: increment, decrement, hold
module lcd_serial_command_decoder
  import lcd_cmd_pkg::*;
#(
  parameter int         FIFO_DEPTH   = 32,
  parameter logic [1:0] PTR_INC_CODE = 2'b00,
  parameter logic [1:0] PTR_DEC_CODE = 2'b01,
  parameter int         FRAME_BASE   = 5000
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Serial link pins
  input  wire logic       serClk,
  input  wire logic       serIn,
  input  wire logic       cmdSel,
  input  wire logic       chipSelN,
  output logic            serOutBusy,
  output logic            serOutBusyEn,
  // Multi-chip sync pin
  input  wire logic       syncIn,
  output logic            syncOut,
  output logic            syncOutEn,
  // Configuration state
  output logic            drive16Row,
  output logic            rowPortAlt,
  output logic            ramBank,
  output logic            syncMaster,
  output logic [2:0]      frameRate,
  output logic            displayOn,
  output logic            frameTick,
  // Display refresh read port
  input  wire logic [5:0] scanAddr,
  output logic [7:0]      scanData
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic [1:0] rstPipe;   // Reset release chain
  logic       rstN;      // Synchronised reset
  logic [4:0] pinMeta;   // First stage, read only by pinSync
  logic [4:0] pinSync;   // {sync, csN, cmdSel, serIn, serClk}
  logic       sckLast;   // Previous serial clock level
  logic       syncLast;  // Previous sync pin level

  // Release reset cleanly against sys_clk
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstN = rstPipe[1];

  // Two flops on every host pin
  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
    begin
      pinMeta  <= PIN_IDLE;
      pinSync  <= PIN_IDLE;
      sckLast  <= 1'b1;  // Idle clock level, so no false edge after reset
      syncLast <= 1'b0;
    end
    else
    begin
      pinMeta  <= {syncIn, chipSelN, cmdSel, serIn, serClk};
      pinSync  <= pinMeta;
      sckLast  <= pinSync[0];
      syncLast <= pinSync[4];
    end
  end

  wire sckRise   = pinSync[0] && !sckLast;  // Input sample edge
  wire sckFall   = !pinSync[0] && sckLast;  // Output shift edge
  wire csActive  = !pinSync[3];
  wire isCmdPin  = pinSync[2];
  wire syncRise  = pinSync[4] && !syncLast;

  ////////////////////////////////////////////////////////////////////////////
  // Serial receiver
  logic [6:0] inShift;  // Bits gathered so far, MSB first
  logic [2:0] bitCnt;   // Bits received in this byte

  byte_stream_if #(.WIDTH(ENTRY_W)) pushIf ();
  byte_stream_if #(.WIDTH(ENTRY_W)) popIf ();

  // Count and shift only while selected; deselect restarts the byte
  always_ff @(posedge sys_clk)
  begin
    if (!rstN || !csActive)
    begin
      inShift <= 7'h00;
      bitCnt  <= 3'h0;
    end
    else if (sckRise)
    begin
      inShift <= {inShift[5:0], pinSync[1]};
      bitCnt  <= bitCnt + 3'h1;
    end
  end

  // Eighth edge pushes the byte with its command/data flag
  assign pushIf.valid = sckRise && csActive && (bitCnt == LAST_BIT);  // RULE16
  assign pushIf.data  = {isCmdPin, inShift, pinSync[1]};              // RULE14

  byte_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) rxFifo (
    .clk     (sys_clk),
    .rstN    (rstN),
    .inPort  (pushIf),
    .outPort (popIf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Executor state
  typedef enum logic {ST_IDLE, ST_CHAR} exec_state_t;

  exec_state_t state;                   // Executor phase
  data_mode_t  mode;                    // Current data mode
  logic [1:0]  modCode;                 // Pointer move of data mode
  logic [6:0]  ptr;                     // Display RAM pointer
  logic [7:0]  ram [RAM_WORDS];         // Display RAM
  logic [2:0]  modeBits;                // Last mode set bits
  logic [7:0]  charCode;                // Character being drawn
  logic [2:0]  colCnt;                  // Glyph column index
  logic [7:0]  outShift;                // Read data shift register
  logic [FRAME_W-1:0] frameCnt;         // Frame divider

  // Pointer move: increment, decrement, or hold
  function automatic logic [6:0] movePtr(input logic [6:0] p, input logic [1:0] code);
    if (code == PTR_INC_CODE)
      return p + 7'h01;  // RULE18
    else if (code == PTR_DEC_CODE)
      return p - 7'h01;  // RULE18
    else
      return p;
  endfunction

  // Glyph column stand-in; the real character table is not modelled
  function automatic logic [7:0] glyphCol(input logic [7:0] code, input logic [2:0] col);
    return {1'b0, code[6:0] >> col};
  endfunction

  // Decoding of the popped entry
  wire        take     = popIf.valid && popIf.ready;
  wire [7:0]  b        = popIf.data[7:0];
  wire        cmdTake  = take && popIf.data[ENTRY_CMD];       // RULE14
  wire        dataTake = take && !popIf.data[ENTRY_CMD];      // RULE14
  wire        isModeSet = (b & MASK_GROUP) == OPC_MODESET;
  wire        isFrame  = ((b & MASK_GROUP) == OPC_FRAME) && (b[2:0] <= FRAME_MAX);
  wire        isPtrLd  = b[PTR_LOAD_BIT] && (b <= OPC_PTR_MAX);
  wire        isWrCmd  = (b & MASK_DMODE) == OPC_WRITE;
  wire        isRdCmd  = (b & MASK_DMODE) == OPC_READ;
  wire        isAndCmd = (b & MASK_DMODE) == OPC_AND;
  wire        isOrCmd  = (b & MASK_DMODE) == OPC_OR;
  wire        isChrCmd = b == OPC_CHAR;
  wire        isSetBit = (b & MASK_BITCMD) == OPC_SETBIT;
  wire        isClrBit = (b & MASK_BITCMD) == OPC_CLRBIT;
  wire        isBitCmd = isSetBit || isClrBit;
  wire [1:0]  bitMove  = b[BITCMD_MOD_LO +: 2];               // RULE17
  wire [7:0]  bitMask  = 8'(8'h01 << b[2:0]);                 // RULE17
  wire [7:0]  curByte  = ram[ptr];
  wire        charWrite = (state == ST_CHAR);
  wire        rmwMode  = (mode == MODE_WRITE) || (mode == MODE_AND) || (mode == MODE_OR);
  wire        readLoad = (cmdTake && isRdCmd) || (dataTake && mode == MODE_READ);  // RULE7
  wire        readActive = csActive && !isCmdPin && (mode == MODE_READ);

  assign popIf.ready = (state == ST_IDLE);

  // RAM write port select
  wire       ramWe = charWrite || (dataTake && rmwMode) || (cmdTake && isBitCmd);
  wire [7:0] dataResult = (mode == MODE_AND) ? (curByte & b) :  // RULE8
                          (mode == MODE_OR)  ? (curByte | b) :  // RULE9
                          b;                                    // RULE6
  wire [7:0] bitResult  = isSetBit ? (curByte | bitMask)        // RULE12
                                   : (curByte & ~bitMask);      // RULE13
  wire [7:0] ramWd = charWrite ? glyphCol(charCode, colCnt) :  // RULE11
                     cmdTake   ? bitResult : dataResult;

  // Pointer update select
  wire [6:0] next_ptr = charWrite                   ? ptr + 7'h01 :       // RULE11
                        (cmdTake && isPtrLd)        ? b[6:0] :            // RULE5
                        (cmdTake && isBitCmd)       ? movePtr(ptr, bitMove) :
                        (cmdTake && isRdCmd)        ? movePtr(ptr, b[1:0]) :
                        (dataTake && mode != MODE_CHAR) ? movePtr(ptr, modCode) :
                        ptr;

  ////////////////////////////////////////////////////////////////////////////
  // Display RAM, pointer and scan port
  always_ff @(posedge sys_clk)
  begin
    if (ramWe)
      ram[ptr] <= ramWd;
    scanData <= ram[{ramBank && !drive16Row, scanAddr}];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
      ptr <= 7'h00;
    else
      ptr <= next_ptr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command registers
  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
    begin
      mode      <= MODE_WRITE;
      modCode   <= PTR_INC_CODE;
      modeBits  <= MODE_RST;
      frameRate <= FRAME_RST;
      displayOn <= 1'b0;
    end
    else if (cmdTake)
    begin
      // Unlisted opcodes fall through unchanged
      if (isModeSet)
        modeBits <= b[2:0];              // RULE1
      if (isFrame)
        frameRate <= b[2:0];             // RULE4
      if (isWrCmd || isRdCmd || isAndCmd || isOrCmd)
        modCode <= b[1:0];
      if (isWrCmd)
        mode <= MODE_WRITE;              // RULE6
      if (isRdCmd)
        mode <= MODE_READ;               // RULE7
      if (isAndCmd)
        mode <= MODE_AND;                // RULE8
      if (isOrCmd)
        mode <= MODE_OR;                 // RULE9
      if (isChrCmd)
        mode <= MODE_CHAR;               // RULE10
      if (b == OPC_DISP_ON)
        displayOn <= 1'b1;
      if (b == OPC_DISP_OFF)
        displayOn <= 1'b0;
    end
  end

  // Mode bits fan out to drive, row port, bank and sync roles
  assign drive16Row = modeBits[MODE_DRIVE];  // RULE1
  assign rowPortAlt = modeBits[MODE_DRIVE];  // RULE2
  assign ramBank    = modeBits[MODE_BANK];   // RULE3
  assign syncMaster = modeBits[MODE_SYNCM];  // RULE3

  ////////////////////////////////////////////////////////////////////////////
  // Character drawing: five columns, one per cycle, FIFO held meanwhile
  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
    begin
      state    <= ST_IDLE;
      colCnt   <= 3'h0;
      charCode <= 8'h00;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (dataTake && mode == MODE_CHAR)
          begin
            state    <= ST_CHAR;  // RULE10
            charCode <= b;
            colCnt   <= 3'h0;
          end
        ST_CHAR:
          if (colCnt == GLYPH_COLS - 3'h1)
            state <= ST_IDLE;
          else
            colCnt <= colCnt + 3'h1;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-out shifter and the shared output/busy pin
  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
      outShift <= 8'h00;
    else if (readLoad)
      outShift <= curByte;                    // RULE7
    else if (sckFall && readActive)
      outShift <= {outShift[6:0], 1'b0};
  end

  // Read data bit while reading, otherwise busy high when the FIFO cannot take another byte
  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
    begin
      serOutBusy   <= 1'b0;
      serOutBusyEn <= 1'b0;
    end
    else
    begin
      serOutBusy   <= readActive ? outShift[7] : !pushIf.ready;  // RULE15
      serOutBusyEn <= csActive;                                  // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame divider and multi-chip sync
  wire [FRAME_W-1:0] frameLimit = FRAME_W'(FRAME_BASE) << frameRate;
  wire               localTick  = (frameCnt >= frameLimit - FRAME_W'(1));

  always_ff @(posedge sys_clk)
  begin
    if (!rstN)
    begin
      frameCnt  <= '0;
      frameTick <= 1'b0;
      syncOut   <= 1'b0;
      syncOutEn <= 1'b0;
    end
    else
    begin
      frameCnt  <= localTick ? '0 : frameCnt + FRAME_W'(1);
      frameTick <= syncMaster ? localTick : syncRise;  // RULE3
      syncOut   <= localTick;
      syncOutEn <= syncMaster;                         // RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstN);

  a_mode_set_bits: assert property (cmdTake && isModeSet |=> modeBits == $past(b[2:0])) // RULE1
    else $error("mode set bits not stored");
  a_sync_role: assert property (cmdTake && isModeSet |-> ##2 syncOutEn == $past(b[2], 2)) // RULE3
    else $error("sync port role not taken");
  a_frame_rate: assert property (cmdTake && isFrame |=> frameRate == $past(b[2:0])) // RULE4
    else $error("frame rate not stored");
  a_ptr_load: assert property (cmdTake && isPtrLd |=> ptr == $past(b[6:0])) // RULE5
    else $error("pointer load wrong");
  a_write_store: assert property (dataTake && mode == MODE_WRITE |=> ram[$past(ptr)] == $past(b)) // RULE6
    else $error("write mode byte not stored");
  a_read_load: assert property (cmdTake && isRdCmd |=> outShift == $past(curByte)) // RULE7
    else $error("read byte not loaded");
  a_and_merge: assert property (dataTake && mode == MODE_AND |=> ram[$past(ptr)] == ($past(b) & $past(curByte))) // RULE8
    else $error("AND result wrong");
  a_or_merge: assert property (dataTake && mode == MODE_OR |=> ram[$past(ptr)] == ($past(b) | $past(curByte))) // RULE9
    else $error("OR result wrong");
  a_char_advance: assert property (dataTake && mode == MODE_CHAR |-> ##6 ptr == $past(ptr, 6) + 7'h05) // RULE11
    else $error("character pointer advance wrong");
  a_set_bit: assert property (cmdTake && isSetBit |=> ram[$past(ptr)][$past(b[2:0])]) // RULE12
    else $error("bit not set");
  a_clr_bit: assert property (cmdTake && isClrBit |=> !ram[$past(ptr)][$past(b[2:0])]) // RULE13
    else $error("bit not cleared");
  a_busy_full: assert property (!pushIf.ready && !readActive |=> serOutBusy) // RULE15
    else $error("busy low while full");
  a_cs_idle: assert property (!csActive |=> bitCnt == 3'h0 && !serOutBusyEn) // RULE16
    else $error("deselected link still active");

  c_char_drawn: cover property (dataTake && mode == MODE_CHAR ##6 state == ST_IDLE);
  c_read_out: cover property (readLoad ##[1:200] sckFall && readActive);
  c_fifo_full: cover property (!pushIf.ready);
  c_bit_cmd: cover property (cmdTake && isBitCmd);

endmodule

// ### test/serial_host_model.sv
// Host side of the serial link: shifts bytes in and reads bytes back.
// Assumes the bench clock paces every pin change, 400 ns per serial bit.
module serial_host_model (
  // Pacing clock
  input wire logic sysClk,
  // Link pins
  output logic     serClk,
  output logic     serIn,
  output logic     cmdSel,
  output logic     chipSelN,
  input wire logic serOutBusy
);
  timeunit 1ns;
  timeprecision 1ns;

  int busyTimeouts = 0;  // Busy never dropped within the wait limit

  // Idle link: clock stands high, chip deselected
  initial
  begin
    serClk = 1'b1;
    serIn = 1'b0;
    cmdSel = 1'b1;
    chipSelN = 1'b1;
  end

  // Half a serial clock period, landing just after a system clock edge
  task automatic half();
    repeat (4) @(posedge sysClk);
    #2;
  endtask

  // Byte MSB first; fewer bits than eight make a broken transfer
  task automatic sendByte(input logic isCmd, input logic [7:0] b, input int nBits = 8);
    cmdSel = isCmd;
    chipSelN = 1'b0;
    half();
    for (int w = 0; w < 400 && serOutBusy !== 1'b0; w++) @(posedge sysClk);
    if (serOutBusy !== 1'b0) busyTimeouts++;
    half();
    for (int i = 0; i < nBits; i++)
    begin
      serClk = 1'b0;
      serIn = b[7-i];
      half();
      serClk = 1'b1;
      half();
    end
    half();
    chipSelN = 1'b1;
    // Released data line must not keep looking valid
    serIn = ~serIn;
    repeat (12) @(posedge sysClk);
    #2;
  endtask

  // Read mode byte: sample before each falling edge shifts the next bit
  task automatic readByte(output logic [7:0] b);
    cmdSel = 1'b0;
    chipSelN = 1'b0;
    half();
    half();
    for (int i = 0; i < 8; i++)
    begin
      b[7-i] = serOutBusy;
      serClk = 1'b0;
      serIn = 1'b0;
      half();
      serClk = 1'b1;
      half();
    end
    half();
    chipSelN = 1'b1;
    serIn = 1'b1;
    repeat (12) @(posedge sysClk);
    #2;
  endtask
endmodule

// ### test/lcd_serial_command_decoder_tb_top.sv
// Bench for the serial command decoder: host model drives the link,
// display RAM is inspected through the scan port. Frame base shortened to 8.
`define CHK(what, exp, got) begin checkCount++; if ((got) !== (exp)) begin fails++; $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module lcd_serial_command_decoder_tb_top;
  import lcd_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic       sysClk, nrst, serClk, serIn, cmdSel, chipSelN, syncIn;
  logic       serOutBusy, serOutBusyEn, syncOut, syncOutEn, frameTick;
  logic       drive16Row, rowPortAlt, ramBank, syncMaster, displayOn;
  logic [2:0] frameRate;
  logic [5:0] scanAddr;
  logic [7:0] scanData, rd;
  int         fails, checkCount, ticks, syncs;
  // Released pin reads as busy, so the host cannot start before the enable
  wire        soPin = serOutBusyEn ? serOutBusy : 1'b1;

  lcd_serial_command_decoder #(.FRAME_BASE(8)) i_dut (.sys_clk(sysClk), .nrst(nrst), .serClk(serClk),
    .serIn(serIn), .cmdSel(cmdSel), .chipSelN(chipSelN), .serOutBusy(serOutBusy), .serOutBusyEn(serOutBusyEn),
    .syncIn(syncIn), .syncOut(syncOut), .syncOutEn(syncOutEn), .drive16Row(drive16Row), .rowPortAlt(rowPortAlt),
    .ramBank(ramBank), .syncMaster(syncMaster), .frameRate(frameRate), .displayOn(displayOn),
    .frameTick(frameTick), .scanAddr(scanAddr), .scanData(scanData));

  serial_host_model i_host (.sysClk(sysClk), .serClk(serClk), .serIn(serIn), .cmdSel(cmdSel),
    .chipSelN(chipSelN), .serOutBusy(soPin));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial
  begin
    sysClk = 1'b0;
    forever #25 sysClk = ~sysClk;
  end

  task automatic cmd(input logic [7:0] b);
    i_host.sendByte(1'b1, b);
  endtask

  task automatic dat(input logic [7:0] b);
    i_host.sendByte(1'b0, b);
  endtask

  // Scan port has one cycle of latency; two edges leave margin
  task automatic ramChk(input logic [5:0] a, input logic [7:0] e);
    @(posedge sysClk);
    #2;
    scanAddr = a;
    repeat (2) @(posedge sysClk);
    #2;
    `CHK("scanData", e, scanData)
  endtask

  // Pulses of frameTick over a fixed span
  task automatic countTicks(input int span);
    ticks = 0;
    syncs = 0;
    repeat (span)
    begin
      @(posedge sysClk);
      #2;
      if (frameTick === 1'b1) ticks++;
      if (syncOut === 1'b1) syncs++;
    end
  endtask

  task automatic stopTest();
    fails += i_host.busyTimeouts;
    $display("checks %0d fails %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Mode, frame and display commands, plus a broken transfer
  task automatic testConfig();
    `CHK("cfgRst", 8'h00, {drive16Row, ramBank, syncMaster, frameRate, displayOn, serOutBusyEn})
    cmd(8'h1D);
    `CHK("mode1D", 5'h1B, {drive16Row, rowPortAlt, ramBank, syncMaster, syncOutEn})
    cmd(8'h1A);
    `CHK("mode1A", 3'h2, {drive16Row, ramBank, syncMaster})
    for (int f = 0; f < 5; f++)
    begin
      cmd(8'h10 | 8'(f));
      `CHK("frameRate", 3'(f), frameRate)
    end
    cmd(8'h15);
    `CHK("frameBad", 3'h4, frameRate)
    cmd(8'h09);
    `CHK("displayOn", 1'b1, displayOn)
    cmd(8'h08);
    `CHK("displayOff", 1'b0, displayOn)
    // Half a byte then deselect: must not merge with the next byte
    i_host.sendByte(1'b1, 8'hFF, 4);
    cmd(8'h18);
    `CHK("modeAbort", 3'h0, {drive16Row, ramBank, syncMaster})
    $display("test config done");
  endtask

  // Local divider as master, pin-driven ticks as slave
  task automatic testFrame();
    cmd(8'h10);
    cmd(8'h1C);
    countTicks(80);
    `CHK("masterTicks", 10, ticks)
    `CHK("syncOutTicks", 10, syncs)
    cmd(8'h18);
    `CHK("syncOutEn", 1'b0, syncOutEn)
    syncIn = 1'b1;
    countTicks(20);
    `CHK("slaveRise", 1, ticks)
    syncIn = 1'b0;
    countTicks(20);
    `CHK("slaveTicks", 0, ticks)
    $display("test frame done");
  endtask

  // Pointer load, write with increment, decrement and hold
  task automatic testWrite();
    cmd(8'h85);
    cmd(8'h64);
    dat(8'hAA);
    dat(8'h55);
    cmd(8'h65);
    dat(8'h11);
    dat(8'h22);
    ramChk(6'd6, 8'h22);
    ramChk(6'd7, 8'h11);
    cmd(8'h66);
    dat(8'h33);
    dat(8'h44);
    ramChk(6'd5, 8'h44);
    $display("test write done");
  endtask

  // AND, OR, then single-bit commands
  task automatic testLogic();
    cmd(8'h85);
    cmd(8'h6C);
    dat(8'h0F);
    cmd(8'h69);
    dat(8'h50);
    dat(8'h80);
    ramChk(6'd5, 8'h84);
    ramChk(6'd6, 8'h72);
    cmd(8'h86);
    cmd(8'h40);
    cmd(8'h2C);
    cmd(8'h39);
    ramChk(6'd6, 8'h71);
    ramChk(6'd7, 8'h01);
    $display("test logic done");
  endtask

  // Glyph columns, then a write lands five places on
  task automatic testChar();
    cmd(8'h90);
    cmd(8'h72);
    dat(8'h41);
    cmd(8'h64);
    dat(8'hEE);
    for (int c = 0; c < 5; c++) ramChk(6'(16 + c), 8'h41 >> c);
    ramChk(6'd21, 8'hEE);
    $display("test char done");
  endtask

  // Two bytes read back; the second follows the pointer
  task automatic testRead();
    cmd(8'h85);
    cmd(8'h60);
    i_host.readByte(rd);
    `CHK("read5", 8'h84, rd)
    i_host.readByte(rd);
    `CHK("read6", 8'h71, rd)
    $display("test read done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    syncIn = 1'b0;
    scanAddr = 6'h00;
    fails = 0;
    checkCount = 0;
    repeat (16) @(posedge sysClk);
    #2;
    nrst = 1'b1;
    repeat (8) @(posedge sysClk);
    #2;
    testConfig();
    testFrame();
    testWrite();
    testLogic();
    testChar();
    testRead();
    stopTest();
  end

  // Watchdog, well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge sysClk);
    fails++;
    stopTest();
  end
endmodule
